// >>> option_config_registers.sv
// AXI4-Lite option register bank driving static control outputs and a gated, synchronised monitor reset
module option_config_registers
  import option_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic monitor_reset_req,
  output logic monitor_power_on,
  output logic monitor_stop_run,
  output logic monitor_reset_out,
  output logic stop_recovery_short,
  output logic [12:0] stop_recovery_cycles,
  output logic [18:0] watchdog_timeout_cycles,
  output logic watchdog_enable,
  output logic stop_insn_legal,
  output logic divider_clock_select
);
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] opt_one;
  logic [7:0] opt_two;
  logic one_locked;
  logic two_locked;
  logic mon_req_s1_r;
  logic mon_req_s2_r;

  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire wr_hit_one = awaddr_r[7:2] == OPT_ONE_IDX[5:0];
  wire wr_hit_two = awaddr_r[7:2] == OPT_TWO_IDX[5:0];
  wire wr_ok = wr_hit_one || wr_hit_two;
  wire wr_one = wr_fire && wr_hit_one && wstrb0_r;
  wire wr_two = wr_fire && wr_hit_two && wstrb0_r;
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire rd_take = s_axi_arvalid && !rvalid_r;
  wire rd_one = rd_idx == OPT_ONE_IDX[5:0];
  wire rd_two = rd_idx == OPT_TWO_IDX[5:0];
  // Lock flags stay internal: their index lies beyond the 8-bit address, and a cut compare would alias index 0
  wire [31:0] rd_word = rd_one ? {24'h000000, opt_one} :
                        rd_two ? {24'h000000, opt_two} : 32'h00000000;

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        // Locked writes still answer OKAY, matching a silent write-once latch
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_one || rd_two) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  option_write_once #(.MASK(OPT_ONE_MASK)) u_opt_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_one),
    .wr_data(wdata_r),
    .value_r(opt_one),
    .locked_r(one_locked)
  );
  option_write_once #(.MASK(OPT_TWO_MASK)) u_opt_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_two),
    .wr_data(wdata_r),
    .value_r(opt_two),
    .locked_r(two_locked)
  );

  // Monitor request is asynchronous to the bus clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_req_s1_r <= 1'b0;
      mon_req_s2_r <= 1'b0;
    end else begin
      mon_req_s1_r <= monitor_reset_req;
      mon_req_s2_r <= mon_req_s1_r;
    end
  end

  assign monitor_power_on = !opt_one[BIT_MON_PWR_DIS];
  assign monitor_stop_run = !opt_one[BIT_MON_PWR_DIS] && opt_one[BIT_MON_STOP_EN];
  assign monitor_reset_out = mon_req_s2_r && !opt_one[BIT_MON_RST_DIS] && !opt_one[BIT_MON_PWR_DIS];
  assign stop_recovery_short = opt_one[BIT_SHORT_REC];
  assign stop_recovery_cycles = opt_one[BIT_SHORT_REC] ? 13'(STOP_REC_SHORT) : 13'(STOP_REC_LONG);
  assign watchdog_timeout_cycles = opt_one[BIT_WDOG_RATE] ? 19'(WDOG_LONG) : 19'(WDOG_SHORT);
  assign watchdog_enable = !opt_one[BIT_WDOG_DIS];
  assign stop_insn_legal = opt_one[BIT_STOP_INSN];
  assign divider_clock_select = opt_two[BIT_DIV_CLK];

  chk_monitor_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    monitor_stop_run |-> monitor_power_on && opt_one[BIT_MON_STOP_EN])
    else $error("monitor runs in stop while powered down or not enabled");
  chk_reset_block: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_one[BIT_MON_RST_DIS] |-> !monitor_reset_out)
    else $error("monitor reset passed while disabled");
  chk_monitor_power: assert property (@(posedge aclk) disable iff (!aresetn)
    monitor_power_on != opt_one[BIT_MON_PWR_DIS])
    else $error("monitor power does not follow option bit");
  chk_stop_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_recovery_cycles == (stop_recovery_short ? 13'h0020 : 13'h1000))
    else $error("stop recovery count wrong");
  chk_wdog_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_timeout_cycles == (opt_one[BIT_WDOG_RATE] ? 19'h3fff0 : 19'h01ff0))
    else $error("watchdog timeout wrong");
  chk_stop_insn: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_one && !one_locked |=> stop_insn_legal == $past(wdata_r[BIT_STOP_INSN]))
    else $error("stop legality not taken from first write");
  chk_wdog_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_one && !one_locked |=> watchdog_enable == !$past(wdata_r[BIT_WDOG_DIS]))
    else $error("watchdog enable not taken from first write");
  chk_div_select: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_two && !two_locked |=> divider_clock_select == $past(wdata_r[BIT_DIV_CLK]))
    else $error("divider clock select not taken from write");
  chk_read_value: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && rd_one |=> rvalid_r && rdata_r == {24'h000000, $past(opt_one)})
    else $error("read of first option register wrong");
  chk_write_once: assert property (@(posedge aclk) disable iff (!aresetn)
    one_locked && two_locked |=> $stable(opt_one) && $stable(opt_two))
    else $error("locked option register changed");
endmodule : option_config_registers

// >>> option_cfg_pkg.sv
// Package holding register map, field positions and timing constants for the option registers
// Behaviour
// - While monitor power is enabled, monitor_stop_enable set keeps the monitor running in stop mode, clear turns it off.
// - A set monitor_reset_disable blocks monitor reset requests, a clear one lets them reach system reset while monitor power is enabled.
// - A set monitor_power_disable powers the low-voltage monitor down, a clear one powers it.
// - short_stop_recovery selects a stop exit delay of 32 reference cycles when set and 4096 when clear.
// - watchdog_rate_select picks a timeout of 2^18-16 reference cycles when set and 2^13-16 when clear.
// - stop_enable set lets the stop instruction run, clear makes it an illegal opcode.
// - watchdog_disable set disables the watchdog module, clear enables it.
// - divider_clock_select set routes the bus clock to the memory timebase divider, clear the reference clock.
// - Each option register accepts one write after reset and ignores later writes until the next reset.
// - Reset clears every option bit and re-arms the write-once permission.
// - The registers decode at 0x1f and 0x3f, are always readable and reads have no side effects.
package option_cfg_pkg;
  localparam logic [7:0] OPT_ONE_IDX = 8'h1f;
  localparam logic [7:0] OPT_TWO_IDX = 8'h3f;
  localparam logic [7:0] OPT_LOCK_IDX = 8'h40;
  localparam logic [7:0] OPT_RESET_VAL = 8'h00;
  localparam int BIT_STOP_EN = 0;
  localparam int BIT_WDOG_DIS = 0;
  localparam int BIT_STOP_INSN = 1;
  localparam int BIT_WDOG_RATE = 2;
  localparam int BIT_SHORT_REC = 3;
  localparam int BIT_MON_PWR_DIS = 4;
  localparam int BIT_MON_RST_DIS = 5;
  localparam int BIT_MON_STOP_EN = 6;
  localparam int BIT_DIV_CLK = 0;
  localparam logic [7:0] OPT_ONE_MASK = 8'h7f;
  localparam logic [7:0] OPT_TWO_MASK = 8'h01;
  localparam int STOP_REC_SHORT = 32;
  localparam int STOP_REC_LONG = 4096;
  localparam int WDOG_LONG = 262128;
  localparam int WDOG_SHORT = 8176;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : option_cfg_pkg

// >>> option_write_once.sv
// One write-once option byte with its lock flag
module option_write_once
  import option_cfg_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value_r,
  output logic locked_r
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_r <= OPT_RESET_VAL;
      locked_r <= 1'b0;
    end else if (wr_en && !locked_r) begin
      value_r <= wr_data & MASK;
      locked_r <= 1'b1;
    end
  end

  chk_lock_holds_value: assert property (@(posedge aclk) disable iff (!aresetn)
    locked_r |=> (value_r == $past(value_r)) && locked_r)
    else $error("locked option byte changed");
  chk_reset_clears: assert property (@(posedge aclk) !aresetn |=> (value_r == OPT_RESET_VAL) && !locked_r)
    else $error("reset did not clear option byte");
endmodule : option_write_once

// >>> option_config_registers_bench.sv
// Self-checking bench for the option register bank
module option_config_registers_bench
  import option_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, req = 0;
  logic [7:0] awaddr = 0, araddr = 0, v1, v2;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic [3:0] strb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic awready, wready, bvalid, arready, rvalid, pwr_on, stop_run, rst_out, short_rec, legal, div_sel, wd_en;
  logic [12:0] rec_cycles;
  logic [18:0] wd_cycles;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt = 0, checked = 0, seed = 43230;
  always #4 aclk = ~aclk;
  option_config_registers i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .monitor_reset_req(req),
    .monitor_power_on(pwr_on), .monitor_stop_run(stop_run), .monitor_reset_out(rst_out),
    .stop_recovery_short(short_rec), .stop_recovery_cycles(rec_cycles), .watchdog_timeout_cycles(wd_cycles),
    .watchdog_enable(wd_en), .stop_insn_legal(legal), .divider_clock_select(div_sel));
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw, pb;
    pa = 1;
    pw = 1;
    pb = 1;
    bq.push_back(er);
    awaddr <= a;
    wdata <= {24'($random(seed)), d};
    wstrb <= strb;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw || pb) begin
      @(posedge aclk);
      if (pa && awready) begin pa = 0; awvalid <= 0; end
      if (pw && wready) begin pw = 0; wvalid <= 0; end
      if (pb && bvalid) begin pb = 0; bready <= 0; end
    end
    // Let an edge pass so the next call does not rewrite bready in this step
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    @(posedge aclk);
  endtask : rd
  // Results are compared against the oldest note when they appear
  always @(posedge aclk) begin
    if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    for (int k = 0; k < 6; k++) begin
      @(posedge aclk);
      aresetn <= 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(8'h7c, 0, RESP_OKAY);
      rd(8'hfc, 0, RESP_OKAY);
      chk("power_on", 1, pwr_on);
      // internal reference assumed, so short recovery may be drawn
      v1 = 8'($random(seed)) & OPT_ONE_MASK;
      v2 = 8'($random(seed)) & OPT_TWO_MASK;
      // lane 0 off neither lands nor locks
      strb = 4'h0;
      wr(8'h7c, OPT_ONE_MASK, RESP_OKAY);
      strb = 4'hf;
      rd(8'h7c, 0, RESP_OKAY);
      wr(8'h7c, v1, RESP_OKAY);
      wr(8'hfc, v2, RESP_OKAY);
      wr(8'h7c, ~v1, RESP_OKAY);
      wr(8'hfc, ~v2, RESP_OKAY);
      rd(8'h7c, v1, RESP_OKAY);
      rd(8'hfc, v2, RESP_OKAY);
      wr(8'h10, v1, RESP_SLVERR);
      rd(8'h10, 0, RESP_SLVERR);
      chk("stop_run", !v1[BIT_MON_PWR_DIS] && v1[BIT_MON_STOP_EN], stop_run);
      chk("power_on", !v1[BIT_MON_PWR_DIS], pwr_on);
      chk("short_rec", v1[BIT_SHORT_REC], short_rec);
      chk("rec_cycles", v1[BIT_SHORT_REC] ? 32 : 4096, rec_cycles);
      chk("wd_cycles", v1[BIT_WDOG_RATE] ? 262128 : 8176, wd_cycles);
      chk("stop_legal", v1[BIT_STOP_INSN], legal);
      chk("wd_enable", !v1[BIT_WDOG_DIS], wd_en);
      chk("div_sel", v2[BIT_DIV_CLK], div_sel);
      req <= 1;
      repeat (3) @(posedge aclk);
      chk("rst_out", !v1[BIT_MON_RST_DIS] && !v1[BIT_MON_PWR_DIS], rst_out);
      req <= 0;
      repeat (3) @(posedge aclk);
      chk("rst_out", 0, rst_out);
      $display("test %0d done with option values %h %h", k, v1, v2);
    end
    tally_and_finish;
  end
endmodule : option_config_registers_bench
